// ### logic/dvc_pkg.sv
// dvc_pkg: shared constants and carrier types for diagnostic verification control
// assumes: ahb-lite register bus, 32-bit data, single clock at 250 MHz
package dvc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_VCMD   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_GATE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DIAG0  = 8'h10;
  localparam logic [7:0] ADDR_DIAG1  = 8'h14;
  localparam logic [7:0] ADDR_DIAG2  = 8'h18;
  localparam logic [7:0] ADDR_CLEAR  = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // verify command bit positions
  localparam int CMD_TEMP_WARN  = 0;
  localparam int CMD_OVERTEMP   = 1;
  localparam int CMD_LREG_UV    = 2;
  localparam int CMD_LREG_OV    = 3;
  localparam int CMD_SUPPLY_UV  = 4;
  localparam int CMD_SUPPLY_OV  = 5;
  localparam int CMD_GATE_UV    = 6;
  localparam int CMD_BOOT_UV    = 7;
  localparam int CMD_DS_OV      = 8;
  localparam int CMD_LPIN_OV    = 9;
  localparam int CMD_OVERCUR    = 10;
  localparam int CMD_W          = 11;
  localparam logic [CMD_W-1:0] CMD_RESET = 11'h000;

  // control register: bit 0 watchdog mode select
  localparam int CTRL_WD_SEL = 0;
  localparam logic CTRL_RESET = 1'b0;

  // gate register: bit0 hi a, bit1 lo a, bit2 hi b, bit3 lo b
  localparam int GATE_HI_A = 0;
  localparam int GATE_LO_A = 1;
  localparam int GATE_HI_B = 2;
  localparam int GATE_LO_B = 3;
  localparam logic [3:0] GATE_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // sticky flag positions inside the flat flag vector
  localparam int FLG_TEMP_WARN = 0;
  localparam int FLG_OVERTEMP  = 1;
  localparam int FLG_WD_EXP    = 2;
  localparam int FLG_LREG_UV   = 3;
  localparam int FLG_LREG_OV   = 4;
  localparam int FLG_GUV_HI_A  = 5;
  localparam int FLG_GUV_LO_A  = 6;
  localparam int FLG_GUV_HI_B  = 7;
  localparam int FLG_GUV_LO_B  = 8;
  localparam int FLG_DS_HI_A   = 9;
  localparam int FLG_DS_LO_A   = 10;
  localparam int FLG_DS_HI_B   = 11;
  localparam int FLG_DS_LO_B   = 12;
  localparam int FLG_SUP_UV    = 13;
  localparam int FLG_SUP_OV    = 14;
  localparam int FLG_BOOT_A    = 15;
  localparam int FLG_BOOT_B    = 16;
  localparam int FLG_OC_A      = 17;
  localparam int FLG_OC_B      = 18;
  localparam int FLG_LPIN_OV   = 19;
  localparam int FLG_W         = 20;
  localparam logic [FLG_W-1:0] FLG_RESET = 20'h00000;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog timeout
  localparam int CLK_MHZ       = 250;
  localparam int WD_TIMEOUT_US = 100;
  localparam int WD_CYCLES     = WD_TIMEOUT_US * CLK_MHZ;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        sel;
  } dvc_bus_req_type;

  typedef enum logic [1:0] {
    WD_IDLE  = 2'b00,
    WD_RUN   = 2'b01,
    WD_DONE  = 2'b10
  } dvc_wd_state_type;

endpackage

// ### logic/dvc_sync.sv
// dvc_sync: three-stage synchroniser for a pin input
// assumes: input may change at any time relative to hclk
`timescale 1ns/1ps
module dvc_sync (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // pin
  input  wire logic pin_in,
  // synchronised level
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change accepted only when stage two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule // dvc_sync

// ### logic/dvc_wdog.sv
// dvc_wdog: enable-watchdog timer started by a change of the enable level
// assumes: enable level already synchronised; one clock domain
`timescale 1ns/1ps
module dvc_wdog #(
  parameter int unsigned TIMEOUT_CYCLES = dvc_pkg::WD_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic wd_sel,
  input  wire logic enable_lvl,
  // result
  output logic      drive_en_q,
  output logic      expired_pulse
);
  dvc_pkg::dvc_wd_state_type state_q;
  logic [31:0]               count_q;
  logic                      enable_prev_q;
  logic                      edge_seen;

  assign edge_seen     = enable_lvl != enable_prev_q;
  assign expired_pulse = (state_q == dvc_pkg::WD_RUN) && (count_q == 32'h0000_0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_prev_q <= 1'b0;
    end else begin
      enable_prev_q <= enable_lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= dvc_pkg::WD_IDLE;
      count_q    <= 32'h0000_0000;
      drive_en_q <= 1'b0;
    end else begin
      case (state_q)
        dvc_pkg::WD_IDLE: begin
          if (wd_sel && edge_seen) begin
            state_q    <= dvc_pkg::WD_RUN;
            count_q    <= TIMEOUT_CYCLES;
            drive_en_q <= 1'b1;
          end
        end
        dvc_pkg::WD_RUN: begin
          // a further change restarts the timer; the controller should hold steady
          if (!wd_sel) begin
            state_q    <= dvc_pkg::WD_IDLE;
            drive_en_q <= 1'b0;
          end else if (edge_seen) begin
            count_q <= TIMEOUT_CYCLES;
          end else if (count_q == 32'h0000_0001) begin
            state_q    <= dvc_pkg::WD_DONE;
            drive_en_q <= 1'b0;
          end else begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
        dvc_pkg::WD_DONE: begin
          if (!wd_sel || edge_seen) begin
            state_q <= dvc_pkg::WD_IDLE;
          end
        end
        default: begin
          state_q <= dvc_pkg::WD_IDLE;
        end
      endcase
    end
  end
endmodule // dvc_wdog

// ### logic/dvc_top.sv
// dvc_top: off-line self-test control of the bridge driver fault detectors
// assumes: ahb-lite slave on hclk; enable pin asynchronous; one clock domain
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dvc_top #(
  parameter int unsigned WD_TIMEOUT_CYCLES = dvc_pkg::WD_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // enable pin
  input  wire logic        enable_pin,
  // to the bridge and sense path
  output logic             fault_flag_q,
  output logic [3:0]       gate_drive_q,
  output logic             sense_full_scale_q
);

  ////////////////////////////////////////////////////////////////////////////
  // bus capture
  dvc_pkg::dvc_bus_req_type req_q;
  logic [dvc_pkg::CMD_W-1:0] vcmd_q;
  logic                      ctrl_q;
  logic [3:0]                gate_q;
  logic [dvc_pkg::FLG_W-1:0] flag_q;
  logic [dvc_pkg::FLG_W-1:0] flag_set;
  logic [dvc_pkg::FLG_W-1:0] flag_clr;
  logic                      wr_en;
  logic                      enable_lvl;
  logic                      wd_drive;
  logic                      wd_expired;
  logic                      any_hi;
  logic                      any_lo;
  logic                      any_on;
  logic                      fault_d;

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] off);
    addr_is = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = req_q.sel && req_q.write;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.sel   <= hsel && htrans[1];
      req_q.write <= hwrite;
      req_q.addr  <= haddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vcmd_q <= dvc_pkg::CMD_RESET;
    end else if (wr_en && addr_is(req_q.addr, dvc_pkg::ADDR_VCMD)) begin
      vcmd_q <= hwdata[dvc_pkg::CMD_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= dvc_pkg::CTRL_RESET;
    end else if (wr_en && addr_is(req_q.addr, dvc_pkg::ADDR_CTRL)) begin
      ctrl_q <= hwdata[dvc_pkg::CTRL_WD_SEL];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q <= dvc_pkg::GATE_RESET;
    end else if (wr_en && addr_is(req_q.addr, dvc_pkg::ADDR_GATE)) begin
      gate_q <= hwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable pin and watchdog
  dvc_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (enable_pin),
    .level_q (enable_lvl)
  );

  dvc_wdog #(
    .TIMEOUT_CYCLES (WD_TIMEOUT_CYCLES)
  ) u_wdog (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .wd_sel        (ctrl_q),
    .enable_lvl    (enable_lvl),
    .drive_en_q    (wd_drive),
    .expired_pulse (wd_expired)
  );

  // in watchdog mode the gates follow phase commands only while the timer runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_drive_q <= 4'h0;
    end else if (ctrl_q) begin
      gate_drive_q <= wd_drive ? gate_q : 4'h0;
    end else begin
      gate_drive_q <= gate_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced detector trips
  assign any_hi = gate_q[dvc_pkg::GATE_HI_A] || gate_q[dvc_pkg::GATE_HI_B];
  assign any_lo = gate_q[dvc_pkg::GATE_LO_A] || gate_q[dvc_pkg::GATE_LO_B];
  assign any_on = any_hi || any_lo;

  always_comb begin
    flag_set = dvc_pkg::FLG_RESET;
    flag_set[dvc_pkg::FLG_TEMP_WARN] = vcmd_q[dvc_pkg::CMD_TEMP_WARN];
    flag_set[dvc_pkg::FLG_OVERTEMP]  = vcmd_q[dvc_pkg::CMD_OVERTEMP];
    flag_set[dvc_pkg::FLG_LREG_UV]   = vcmd_q[dvc_pkg::CMD_LREG_UV];
    flag_set[dvc_pkg::FLG_LREG_OV]   = vcmd_q[dvc_pkg::CMD_LREG_OV];
    flag_set[dvc_pkg::FLG_SUP_UV]    = vcmd_q[dvc_pkg::CMD_SUPPLY_UV];
    flag_set[dvc_pkg::FLG_SUP_OV]    = vcmd_q[dvc_pkg::CMD_SUPPLY_OV];
    flag_set[dvc_pkg::FLG_GUV_HI_A]  = vcmd_q[dvc_pkg::CMD_GATE_UV]
                                     && gate_q[dvc_pkg::GATE_LO_A];
    flag_set[dvc_pkg::FLG_GUV_HI_B]  = vcmd_q[dvc_pkg::CMD_GATE_UV]
                                     && gate_q[dvc_pkg::GATE_LO_B];
    flag_set[dvc_pkg::FLG_GUV_LO_A]  = vcmd_q[dvc_pkg::CMD_GATE_UV]
                                     && gate_q[dvc_pkg::GATE_HI_A];
    flag_set[dvc_pkg::FLG_GUV_LO_B]  = vcmd_q[dvc_pkg::CMD_GATE_UV]
                                     && gate_q[dvc_pkg::GATE_HI_B];
    flag_set[dvc_pkg::FLG_BOOT_A]    = vcmd_q[dvc_pkg::CMD_BOOT_UV]
                                     && gate_q[dvc_pkg::GATE_HI_A];
    flag_set[dvc_pkg::FLG_BOOT_B]    = vcmd_q[dvc_pkg::CMD_BOOT_UV]
                                     && gate_q[dvc_pkg::GATE_HI_B];
    flag_set[dvc_pkg::FLG_DS_HI_A]   = vcmd_q[dvc_pkg::CMD_DS_OV]
                                     && gate_q[dvc_pkg::GATE_LO_A];
    flag_set[dvc_pkg::FLG_DS_HI_B]   = vcmd_q[dvc_pkg::CMD_DS_OV]
                                     && gate_q[dvc_pkg::GATE_LO_B];
    flag_set[dvc_pkg::FLG_DS_LO_A]   = vcmd_q[dvc_pkg::CMD_DS_OV]
                                     && gate_q[dvc_pkg::GATE_HI_A];
    flag_set[dvc_pkg::FLG_DS_LO_B]   = vcmd_q[dvc_pkg::CMD_DS_OV]
                                     && gate_q[dvc_pkg::GATE_HI_B];
    flag_set[dvc_pkg::FLG_LPIN_OV]   = vcmd_q[dvc_pkg::CMD_LPIN_OV];
    flag_set[dvc_pkg::FLG_OC_A]      = vcmd_q[dvc_pkg::CMD_OVERCUR];
    flag_set[dvc_pkg::FLG_OC_B]      = vcmd_q[dvc_pkg::CMD_OVERCUR];
    flag_set[dvc_pkg::FLG_WD_EXP]    = wd_expired;
  end

  // general fault follows the live commands other than overcurrent, never the sticky flags
  always_comb begin
    fault_d = vcmd_q[dvc_pkg::CMD_TEMP_WARN]
           || vcmd_q[dvc_pkg::CMD_OVERTEMP]
           || vcmd_q[dvc_pkg::CMD_LREG_UV]
           || vcmd_q[dvc_pkg::CMD_LREG_OV]
           || vcmd_q[dvc_pkg::CMD_SUPPLY_UV]
           || vcmd_q[dvc_pkg::CMD_SUPPLY_OV]
           || vcmd_q[dvc_pkg::CMD_LPIN_OV]
           || (vcmd_q[dvc_pkg::CMD_GATE_UV] && any_on)
           || (vcmd_q[dvc_pkg::CMD_BOOT_UV] && any_hi)
           || (vcmd_q[dvc_pkg::CMD_DS_OV] && any_on);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_flag_q <= 1'b0;
    end else begin
      fault_flag_q <= fault_d;
    end
  end

  // sense outputs forced to full scale only while the check is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_full_scale_q <= 1'b0;
    end else begin
      sense_full_scale_q <= vcmd_q[dvc_pkg::CMD_OVERCUR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: write-one-to-clear at the clear register, set wins
  assign flag_clr = (wr_en && addr_is(req_q.addr, dvc_pkg::ADDR_CLEAR))
                    ? hwdata[dvc_pkg::FLG_W-1:0] : dvc_pkg::FLG_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < dvc_pkg::FLG_W; gi++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_q[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path: status and diag views are windows onto the flag vector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (addr_is(haddr, dvc_pkg::ADDR_VCMD)) begin
        hrdata <= {21'h000000, vcmd_q};
      end else if (addr_is(haddr, dvc_pkg::ADDR_CTRL)) begin
        hrdata <= {31'h00000000, ctrl_q};
      end else if (addr_is(haddr, dvc_pkg::ADDR_GATE)) begin
        hrdata <= {28'h0000000, gate_q};
      end else if (addr_is(haddr, dvc_pkg::ADDR_STATUS)) begin
        hrdata <= {28'h0000000, fault_flag_q, flag_q[2:0]};
      end else if (addr_is(haddr, dvc_pkg::ADDR_DIAG0)) begin
        hrdata <= {26'h0000000, flag_q[8:3]};
      end else if (addr_is(haddr, dvc_pkg::ADDR_DIAG1)) begin
        hrdata <= {28'h0000000, flag_q[12:9]};
      end else if (addr_is(haddr, dvc_pkg::ADDR_DIAG2)) begin
        hrdata <= {26'h0000000, flag_q[18:13]};
      end else if (addr_is(haddr, dvc_pkg::ADDR_CLEAR)) begin
        hrdata <= {12'h000, flag_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

endmodule // dvc_top

// ### verification/dvc_checker.sv
// dvc_checker: port-level assertions for dvc_top
// assumes: bound into dvc_top; verify, gate and control writes are shadowed from the bus
`timescale 1ns/1ps
module dvc_checker #(
  parameter int unsigned WD_TIMEOUT_CYCLES = dvc_pkg::WD_CYCLES
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // enable pin and outputs
  input wire logic        enable_pin,
  input wire logic        fault_flag_q,
  input wire logic [3:0]  gate_drive_q,
  input wire logic        sense_full_scale_q
);
  ////////////////////////////////////////////////////////////////////////////////
  logic        wv_q;
  logic [7:0]  wa_q;
  logic [10:0] cmd_q;
  logic [3:0]  gate_q;
  logic        wd_q;
  logic        exp_fault;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wv_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  // shadows land on the same edge as the design's registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= dvc_pkg::CMD_RESET;
      gate_q <= dvc_pkg::GATE_RESET;
      wd_q <= dvc_pkg::CTRL_RESET;
    end else if (wv_q && hready) begin
      if (wa_q == dvc_pkg::ADDR_VCMD) cmd_q <= hwdata[10:0];
      if (wa_q == dvc_pkg::ADDR_GATE) gate_q <= hwdata[3:0];
      if (wa_q == dvc_pkg::ADDR_CTRL) wd_q <= hwdata[0];
    end
  end

  assign exp_fault = (|cmd_q[5:0]) | cmd_q[9] | ((cmd_q[6] | cmd_q[8]) & (|gate_q))
                   | (cmd_q[7] & (gate_q[0] | gate_q[2]));

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_release;
    exp_fault ##1 !exp_fault;
  endsequence
  // gate-dependent checks alone with every gate off
  sequence s_quiet;
    !wd_q && ((cmd_q & 11'h63f) == 11'h000) && (gate_q == 4'h0);
  endsequence

  a_fault_live: assert property (!wd_q |=> fault_flag_q == $past(exp_fault))
    else $error("fault flag differs from active checks");
  a_release_drop: assert property (s_release |=> !fault_flag_q)
    else $error("fault flag kept after check release");
  a_temp_fault: assert property (|cmd_q[1:0] |=> fault_flag_q)
    else $error("temperature check without fault");
  a_lreg_fault: assert property (|cmd_q[3:2] |=> fault_flag_q)
    else $error("regulator check without fault");
  a_supply_fault: assert property (|cmd_q[5:4] |=> fault_flag_q)
    else $error("supply check without fault");
  a_gate_fault: assert property ((cmd_q[6] || cmd_q[8]) && gate_q != 4'h0 |=> fault_flag_q)
    else $error("gate or drain check without fault");
  a_boot_fault: assert property (cmd_q[7] && (gate_q[0] || gate_q[2]) |=> fault_flag_q)
    else $error("bootstrap check without fault");
  a_pin_fault: assert property (cmd_q[9] |=> fault_flag_q)
    else $error("logic pin check without fault");
  a_quiet_idle: assert property (s_quiet |=> !fault_flag_q)
    else $error("fault with all gates off");
  a_sense_force: assert property (sense_full_scale_q == $past(cmd_q[dvc_pkg::CMD_OVERCUR]))
    else $error("sense forcing does not follow check");
endmodule // dvc_checker

bind dvc_top dvc_checker #(.WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)) u_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .enable_pin(enable_pin),
  .fault_flag_q(fault_flag_q), .gate_drive_q(gate_drive_q),
  .sense_full_scale_q(sense_full_scale_q)
);

// ### verification/dvc_ctrl_model.sv
// dvc_ctrl_model: external controller, ahb-lite master and enable pin driver
// assumes: tasks are entered right after a rising edge of hclk
`timescale 1ns/1ps
module dvc_ctrl_model (
  // clock and slave answer
  input wire logic        hclk,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // bus request
  output logic            hsel,
  output logic [31:0]     haddr,
  output logic [1:0]      htrans,
  output logic            hwrite,
  output logic [2:0]      hsize,
  output logic [31:0]     hwdata,
  // enable pin
  output logic            enable_pin
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    enable_pin = 1'b0;
  end

  // idle bus lines are scrambled so stale values never look valid
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= wr ? d : ~d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask

  // enable level is held after the change
  task automatic flip_enable();
    enable_pin <= ~enable_pin;
  endtask
endmodule // dvc_ctrl_model

// ### verification/tb_top.sv
// tb_top: self-checking bench for dvc_top
// assumes: dvc_ctrl_model drives the bus; short watchdog count for simulation
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned WDT = 20;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, enable_pin;
  logic        fault_flag_q, sense_full_scale_q;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  gate_drive_q;
  int          errors, compares;

  dvc_top #(.WD_TIMEOUT_CYCLES(WDT)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enable_pin(enable_pin),
    .fault_flag_q(fault_flag_q), .gate_drive_q(gate_drive_q),
    .sense_full_scale_q(sense_full_scale_q));
  dvc_ctrl_model u_ctrl (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .enable_pin(enable_pin));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic exp_fault(input logic [10:0] c, input logic [3:0] g);
    return (|c[5:0]) | c[9] | ((c[6] | c[8]) & (|g)) | (c[7] & (g[0] | g[2]));
  endfunction

  // low side on marks the high-side comparator of that phase, and the reverse
  function automatic logic [31:0] exp_flags(input logic [10:0] c, input logic [3:0] g);
    logic [3:0] sw;
    sw = {g[2], g[3], g[0], g[1]};
    return {12'h000, c[9], {2{c[10]}}, {2{c[7]}} & {g[2], g[0]}, c[5], c[4],
            {4{c[8]}} & sw, {4{c[6]}} & sw, c[3], c[2], 1'b0, c[1], c[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_case(input logic [10:0] c, input logic [3:0] g);
    logic [31:0] f;
    f = exp_flags(c, g);
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_GATE, {28'h0000000, g}, rd);
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_VCMD, {21'h000000, c}, rd);
    repeat (3) @(posedge hclk);
    check(fault_flag_q, exp_fault(c, g), "fault active");
    check(sense_full_scale_q, c[10], "sense forced");
    check(gate_drive_q, g, "gates follow command");
    check(hresp, 1'b0, "response okay");
    u_ctrl.xfer(1'b0, dvc_pkg::ADDR_CLEAR, 32'h0, rd);
    check(rd, f, "flags set");
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_VCMD, 32'h0, rd);
    repeat (3) @(posedge hclk);
    check(fault_flag_q, 1'b0, "fault released");
    check(sense_full_scale_q, 1'b0, "sense released");
    u_ctrl.xfer(1'b0, dvc_pkg::ADDR_CLEAR, 32'h0, rd);
    check(rd, f, "flags kept");
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_CLEAR, 32'h000f_ffff, rd);
    repeat (2) @(posedge hclk);
    u_ctrl.xfer(1'b0, dvc_pkg::ADDR_CLEAR, 32'h0, rd);
    check(rd, 32'h0, "flags cleared");
  endtask

  initial begin
    hresetn = 1'b0;
    errors = 0;
    compares = 0;
    seed = 32'd42;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    u_ctrl.xfer(1'b1, 32'h40, 32'hffff_ffff, rd);
    for (int a = 0; a <= 64; a += 4) begin
      u_ctrl.xfer(1'b0, a, 32'h0, rd);
      check(rd, 32'h0, "reset or unmapped");
    end
    // every check against every single switch and all off
    for (int i = 0; i < 11; i++) begin
      for (int g = 0; g < 5; g++) begin
        run_case(11'h001 << i, 4'h1 << g);
      end
    end
    for (int n = 0; n < 40; n++) begin
      seed = xorshift(seed);
      run_case(seed[10:0], seed[15:12]);
    end
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_GATE, 32'h5, rd);
    u_ctrl.xfer(1'b1, dvc_pkg::ADDR_CTRL, 32'h1, rd);
    u_ctrl.xfer(1'b0, dvc_pkg::ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h0, "watchdog idle");
    u_ctrl.flip_enable();
    repeat (10) @(posedge hclk);
    check(gate_drive_q, 4'h5, "gates enabled");
    repeat (2 * WDT) @(posedge hclk);
    u_ctrl.xfer(1'b0, dvc_pkg::ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h4, "watchdog expired");
    check(gate_drive_q, 4'h0, "gates off after expiry");
    give_verdict();
  end

  // the run needs about 2200 cycles
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule // tb_top
